/* File: src/eeprom_host_pkg.sv */
/*
  Constants, command codes and carrier structs for the parallel EEPROM
  page-write host controller.
  Assumes a 200 MHz clock and an EEPROM wired directly to the host pins.
*/
// How it works
// - Page address bits constant on every data load.
// - Output enable high while strobes low.
// - A page holds one to sixty-four bytes.
// - Next load within byte load window.
// - Page fixed after command code entered.
package eeprom_host_pkg;

  // ****************************************************************
  // Geometry and timing
  // ****************************************************************
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned PAGE_W     = 7;
  localparam int unsigned COL_W      = 6;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned CLK_PS     = 5000;
  localparam int unsigned WP_NS      = 100;   // Write pulse low
  localparam int unsigned WPH_NS     = 50;    // Write pulse high
  localparam int unsigned RD_NS      = 120;   // Poll read access
  localparam int unsigned OEHP_NS    = 150;   // Output enable high pulse
  localparam int unsigned BLC_US     = 150;   // Byte load window
  localparam int unsigned TWC_US     = 10000; // Write cycle time
  localparam int unsigned SYNC_CYC   = 2;
  localparam int unsigned WP_CYC     = (WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WPH_CYC    = (WPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RD_CYC     = (RD_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_CYC;
  localparam int unsigned OEHP_CYC   = (OEHP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned BLC_CYC    = BLC_US * 1000 / (CLK_PS / 1000);
  localparam int unsigned TWC_CYC    = TWC_US * 1000 / (CLK_PS / 1000);
  localparam int unsigned LOAD_CYC   = WP_CYC + WPH_CYC + 4;
  localparam int unsigned TMR_W      = 21;
  localparam int unsigned ARM_LEN    = 3;
  localparam int unsigned DISARM_LEN = 6;

  // ****************************************************************
  // Command prefix addresses and codes
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CMD_ADDR_A = 13'h1555;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B = 13'h0AAA;
  localparam logic [7:0]        CODE_AA    = 8'hAA;
  localparam logic [7:0]        CODE_55    = 8'h55;
  localparam logic [7:0]        CODE_ARM   = 8'hA0;
  localparam logic [7:0]        CODE_ERASE = 8'h80;
  localparam logic [7:0]        CODE_OFF   = 8'h20;

  typedef enum logic [1:0] {OP_WRITE, OP_ARM, OP_DISARM} op_e;

  // User command
  typedef struct packed {
    op_e               op;
    logic [ADDR_W-1:0] addr;
    logic [6:0]        count;
  } cmd_s;

  // EEPROM pin outputs
  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        dout;
    logic              dout_en;
  } pins_s;

  // Completion status
  typedef struct packed {
    logic done;
    logic timed_out;
    logic short_page;
    logic locked;
  } stat_s;

endpackage

/* File: src/sync2.sv */
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes each bit is independently sampled; no word coherence.
*/
module sync2 #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: src/eeprom_page_host.sv */
/*
  Host controller that loads pages, arms and disarms the soft_write_lock
  of a byte-wide parallel EEPROM through its pins, then polls
  data_bit_seven for the end of the internal write.
  Assumes the pins connect directly and the user feeds bytes promptly.
*/
module eeprom_page_host
  import eeprom_host_pkg::*;
#(
  parameter int unsigned BLC_CYCLES = eeprom_host_pkg::BLC_CYC,
  parameter int unsigned TWC_CYCLES = eeprom_host_pkg::TWC_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  cmd_valid,
  input  wire eeprom_host_pkg::cmd_s cmd,
  output logic                       cmd_ready,
  input  wire logic                  byte_valid,
  input  wire logic [7:0]            byte_data,
  output logic                       byte_ready,
  output eeprom_host_pkg::stat_s     status,
  output eeprom_host_pkg::pins_s     pins,
  input  wire logic [7:0]            din
);
  import eeprom_host_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_NEXT, S_FETCH, S_LOW, S_HIGH, S_RD, S_RDGAP, S_DONE}
    state_e;

  typedef struct packed {
    state_e             st;
    pins_s              pins;
    stat_s              stat;
    logic               cmd_ready;
    logic               byte_ready;
    op_e                op;
    logic [PAGE_W-1:0]  page;
    logic [COL_W-1:0]   col;
    logic [2:0]         step;
    logic [2:0]         plen;
    logic [6:0]         left;
    logic               expect7;
    logic               seen7;
    logic [TMR_W-1:0]   tmr;
    logic [TMR_W-1:0]   wc;
    logic [TMR_W-1:0]   win;
  } ctl_s;

  localparam logic [TMR_W-1:0] WIN_GIVEUP = TMR_W'(BLC_CYCLES - LOAD_CYC - 2);
  localparam logic [TMR_W-1:0] TWC_LIM    = TMR_W'(TWC_CYCLES);
  localparam logic [TMR_W-1:0] WIN_LAPSED = TMR_W'(BLC_CYCLES);

  ctl_s       s_q;
  ctl_s       s_d;
  logic [7:0] din_s;

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  sync2 #(.W(8)) u_din_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (din),
    .q       (din_s)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Command prefix address and code for one step
  function automatic logic [ADDR_W+7:0] prefix(input op_e op, input logic [2:0] idx);
    logic [ADDR_W+7:0] r;
    r = {CMD_ADDR_A, CODE_AA};
    case (idx)
      3'd1:    r = {CMD_ADDR_B, CODE_55};
      3'd2:    r = {CMD_ADDR_A, (op == OP_DISARM) ? CODE_ERASE : CODE_ARM};
      3'd4:    r = {CMD_ADDR_B, CODE_55};
      3'd5:    r = {CMD_ADDR_A, CODE_OFF};
      default: r = {CMD_ADDR_A, CODE_AA};
    endcase
    return r;
  endfunction

  // Saturating counter step
  function automatic logic [TMR_W-1:0] bump(input logic [TMR_W-1:0] v);
    return (&v) ? v : v + TMR_W'(1);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    s_d             = s_q;
    s_d.stat.done   = 1'b0;
    s_d.tmr         = bump(s_q.tmr);
    s_d.wc          = bump(s_q.wc);
    s_d.win         = bump(s_q.win);
    case (s_q.st)
      S_IDLE:
      begin
        s_d.cmd_ready = 1'b1;
        if (cmd_valid && s_q.cmd_ready)
        begin
          s_d.cmd_ready       = 1'b0;
          s_d.stat.timed_out  = 1'b0;
          s_d.stat.short_page = 1'b0;
          s_d.op              = cmd.op;
          s_d.page            = cmd.addr[ADDR_W-1:COL_W];
          s_d.col             = cmd.addr[COL_W-1:0];
          s_d.step            = 3'd0;
          s_d.win             = '0;
          // Clamp to one page; writes load at least one byte
          s_d.left = (cmd.count > 7'(PAGE_BYTES)) ? 7'(PAGE_BYTES) : cmd.count;
          if (cmd.op == OP_WRITE && cmd.count == 7'd0)
            s_d.left = 7'd1;
          case (cmd.op)
            OP_ARM:    s_d.plen = 3'(ARM_LEN);
            OP_DISARM: s_d.plen = 3'(DISARM_LEN);
            // Locked part needs the prefix or the write is lost
            default:   s_d.plen = s_q.stat.locked ? 3'(ARM_LEN) : 3'd0;
          endcase
          s_d.st = S_NEXT;
        end
      end
      S_NEXT:
      begin
        if (s_q.step < s_q.plen)
        begin
          {s_d.pins.addr, s_d.pins.dout} = prefix(s_q.op, s_q.step);
          s_d.step    = s_q.step + 3'd1;
          s_d.tmr     = '0;
          s_d.st      = S_LOW;
        end
        else if (s_q.left != 7'd0)
        begin
          s_d.byte_ready = 1'b1;
          s_d.st         = S_FETCH;
        end
        else
        begin
          s_d.wc = '0;
          s_d.st = S_RD;
          s_d.tmr = '0;
        end
      end
      S_FETCH:
      begin
        if (byte_valid && s_q.byte_ready)
        begin
          s_d.byte_ready = 1'b0;
          s_d.pins.addr  = {s_q.page, s_q.col};
          s_d.pins.dout  = byte_data;
          s_d.col        = s_q.col + COL_W'(1);
          s_d.left       = s_q.left - 7'd1;
          s_d.tmr        = '0;
          s_d.st         = S_LOW;
        end
        else if (s_q.win >= WIN_GIVEUP)
        begin
          // Window about to lapse: close the page with what is loaded
          s_d.byte_ready      = 1'b0;
          s_d.left            = 7'd0;
          s_d.stat.short_page = 1'b1;
          s_d.wc              = '0;
          s_d.tmr             = '0;
          s_d.st              = S_RD;
        end
      end
      S_LOW:
      begin
        // Strobes low, output enable held high
        s_d.pins.ce_n    = 1'b0;
        s_d.pins.we_n    = 1'b0;
        s_d.pins.oe_n    = 1'b1;
        s_d.pins.dout_en = 1'b1;
        s_d.win          = '0;
        s_d.expect7      = s_q.pins.dout[7];
        if (s_q.tmr >= TMR_W'(WP_CYC))
        begin
          s_d.pins.ce_n = 1'b1;
          s_d.pins.we_n = 1'b1;
          s_d.tmr       = '0;
          s_d.st        = S_HIGH;
        end
      end
      S_HIGH:
      begin
        // Data and address held through the high time
        if (s_q.tmr >= TMR_W'(WPH_CYC))
        begin
          s_d.pins.dout_en = 1'b0;
          s_d.st           = S_NEXT;
        end
      end
      S_RD:
      begin
        // Polling read of data_bit_seven
        s_d.pins.ce_n    = 1'b0;
        s_d.pins.oe_n    = 1'b0;
        s_d.pins.dout_en = 1'b0;
        if (s_q.tmr >= TMR_W'(RD_CYC))
        begin
          s_d.seen7     = din_s[7];
          s_d.pins.ce_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          s_d.tmr       = '0;
          s_d.st        = S_RDGAP;
        end
      end
      S_RDGAP:
      begin
        if (s_q.tmr >= TMR_W'(OEHP_CYC))
        begin
          s_d.tmr = '0;
          if (s_q.win <= WIN_LAPSED)
          begin
            // Device may still be loading; its write has not begun
            s_d.wc = '0;
            s_d.st = S_RD;
          end
          else if (s_q.seen7 == s_q.expect7)
            s_d.st = S_DONE;
          else if (s_q.wc >= TWC_LIM)
          begin
            s_d.stat.timed_out = 1'b1;
            s_d.st             = S_DONE;
          end
          else
            s_d.st = S_RD;
        end
      end
      S_DONE:
      begin
        // Lock state follows the sequence once the write period ends
        if (s_q.op == OP_ARM)
          s_d.stat.locked = 1'b1;
        else if (s_q.op == OP_DISARM)
          s_d.stat.locked = 1'b0;
        s_d.stat.done = 1'b1;
        s_d.cmd_ready = 1'b1;
        s_d.st        = S_IDLE;
      end
      default:
      begin
        s_d.st = S_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_q              <= '0;
      s_q.st           <= S_IDLE;
      s_q.pins.ce_n    <= 1'b1;
      s_q.pins.we_n    <= 1'b1;
      s_q.pins.oe_n    <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs straight from the state register
  // ****************************************************************
  assign cmd_ready  = s_q.cmd_ready;
  assign byte_ready = s_q.byte_ready;
  assign status     = s_q.stat;
  assign pins       = s_q.pins;

endmodule

/* File: tb/eeprom_page_host_assertions.sv */
/* Checker for the page host pins and handshakes.
   Assumes binding into every eeprom_page_host instance. */
module eeprom_page_host_assertions
  import eeprom_host_pkg::*;
#(
  parameter int unsigned BLC_CYCLES = 200,
  parameter int unsigned TWC_CYCLES = 400
) (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   cmd_valid,
  input wire eeprom_host_pkg::cmd_s  cmd,
  input wire logic                   cmd_ready,
  input wire logic                   byte_valid,
  input wire logic [7:0]             byte_data,
  input wire logic                   byte_ready,
  input wire eeprom_host_pkg::stat_s status,
  input wire eeprom_host_pkg::pins_s pins,
  input wire logic [7:0]             din
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helpers
  // ****************************************
  logic       str, tk_b, tk_c, pend_q, seen_q;
  logic [6:0] pg_q;
  assign str  = !pins.ce_n && !pins.we_n;
  assign tk_b = byte_valid && byte_ready;
  assign tk_c = cmd_valid && cmd_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Page of data loads within one command
  always_ff @(posedge clk)
  begin
    pend_q <= reset_n && (tk_b || (pend_q && !$rose(str)));
    seen_q <= reset_n && !tk_c && (seen_q || ($rose(str) && pend_q));
    if ($rose(str) && pend_q)
      pg_q <= pins.addr[12:6];
  end
  sequence s_data_load;
    $rose(str) && pend_q;
  endsequence
  sequence s_pulse;
    str [*8];
  endsequence
  a_page_same:
    assert property (s_data_load ##0 seen_q |-> pins.addr[12:6] == pg_q)
    else $error("page bits moved between loads");
  a_oe_high_wr:
    assert property (str |-> pins.oe_n)
    else $error("output enable low in write");
  a_load_after_take:
    assert property (tk_b |-> ##[1:3] $rose(str))
    else $error("byte taken but no strobe");
  a_pulse_min:
    assert property ($rose(str) |-> s_pulse)
    else $error("write pulse too short");
  a_data_on:
    assert property (str |-> pins.dout_en)
    else $error("data not driven in strobe");
  a_poll_quiet:
    assert property (!pins.oe_n |-> pins.we_n && !pins.dout_en)
    else $error("poll read while driving");
  a_done_ready:
    assert property (status.done |-> cmd_ready)
    else $error("done without ready");
  a_busy_hold:
    assert property (tk_c |=> !cmd_ready [*8])
    else $error("ready while busy");
  a_lock_at_end:
    assert property ($changed(status.locked) |-> status.done || $past(status.done))
    else $error("lock record moved off end");
endmodule
bind eeprom_page_host eeprom_page_host_assertions #(
  .BLC_CYCLES(BLC_CYCLES), .TWC_CYCLES(TWC_CYCLES)) chk_i (
  .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
  .status(status), .pins(pins), .din(din));

/* File: tb/eeprom_model.sv */
/* Behavioural byte-wide EEPROM with page loads and soft_write_lock.
   Assumes host pins wired straight in; clk samples the strobes for loads and paces timers. */
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter int unsigned WIN = 100,
  parameter int unsigned TW  = 150
) (
  input  wire logic                   clk,
  input  wire eeprom_host_pkg::pins_s pins,
  output logic [7:0]                  din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [8192];
  logic [20:0] la [$];
  logic        lock, busy, str_q, arm, dis;
  logic [7:0]  last;
  int          win, tw, p;
  function automatic logic hit(int k, logic [12:0] a, logic [7:0] d);
    return la.size() > k && la[k] === {a, d};
  endfunction
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {lock, busy, str_q, last, win, tw} = '0;
  end
  // Poll value in write, memory after, inverse when released
  assign din = (pins.ce_n || pins.oe_n) ? ~last
             : busy ? {~last[7], last[6:0]} : mem[pins.addr];
  // Loads, window and internal write
  always @(posedge clk)
  begin
    str_q <= !pins.ce_n && !pins.we_n;
    if (!pins.ce_n && !pins.we_n && !str_q && !busy)
    begin
      la.push_back({pins.addr, pins.dout});
      last <= pins.dout;
      win <= 0;
    end
    else if (la.size() > 0 && !busy)
    begin
      win <= win + 1;
      busy <= win >= WIN;
      tw <= 0;
    end
    else if (busy)
      tw <= tw + 1;
    if (busy && tw >= TW)
    begin
      arm = hit(0, CMD_ADDR_A, CODE_AA) && hit(1, CMD_ADDR_B, CODE_55);
      dis = arm && hit(2, CMD_ADDR_A, CODE_ERASE) && hit(3, CMD_ADDR_A, CODE_AA)
            && hit(4, CMD_ADDR_B, CODE_55) && hit(5, CMD_ADDR_A, CODE_OFF);
      arm = arm && hit(2, CMD_ADDR_A, CODE_ARM);
      p = dis ? 6 : arm ? 3 : 0;
      for (int k = p; k < la.size(); k++)
        if (p > 0 || !lock) mem[la[k][20:8]] <= la[k][7:0];
      lock <= dis ? 1'b0 : arm ? 1'b1 : lock;
      la.delete();
      busy <= 1'b0;
    end
  end
endmodule

/* File: tb/tb_top.sv */
/* Self-checking bench: page host against the EEPROM model.
   Assumes small window and write-time parameters. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n, cmd_valid, cmd_ready, byte_valid, byte_ready;
  logic [7:0] byte_data, din;
  cmd_s       cmd;
  stat_s      status;
  pins_s      pins;
  int         err_count, total_checks;
  eeprom_page_host #(.BLC_CYCLES(200), .TWC_CYCLES(400)) eeprom_page_host_i (
    .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .status(status), .pins(pins), .din(din));
  eeprom_model #(.WIN(100), .TW(150)) eeprom_model_i (.clk(clk), .pins(pins), .din(din));
  // Clock
  always #2.5 clk = ~clk;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One command, nb bytes fed, wait for done
  task automatic run(input op_e op, input logic [12:0] a, input logic [6:0] n, input int nb);
    int g;
    for (g = 0; cmd_ready !== 1'b1 && g < 99; g++) @(negedge clk);
    cmd = '{op, a, n};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int k = 0; k < nb; k++)
    begin
      for (g = 0; byte_ready !== 1'b1 && g < 999; g++) @(negedge clk);
      byte_data = 8'h30 + 8'(k);
      byte_valid = 1'b1;
      @(negedge clk);
      byte_valid = 1'b0;
      @(negedge clk);
    end
    for (g = 0; status.done !== 1'b1 && g < 3000; g++) @(negedge clk);
    check(g < 3000, 1);
  endtask
  task automatic t_page();
    run(OP_WRITE, 13'h0345, 7'd64, 64);
    check(status.short_page, 0);
    check(status.timed_out, 0);
    for (int k = 0; k < 64; k++)
      check(eeprom_model_i.mem[{7'h0D, 6'(5 + k)}], 8'h30 + k);
    $display("test page done");
  endtask
  task automatic t_short();
    run(OP_WRITE, 13'h0100, 7'd3, 1);
    check(status.short_page, 1);
    check(eeprom_model_i.mem[13'h0100], 8'h30);
    check(eeprom_model_i.mem[13'h0101], 8'hFF);
    $display("test short done");
  endtask
  task automatic t_arm();
    run(OP_ARM, 13'h0000, 7'd0, 0);
    check(status.locked, 1);
    check(eeprom_model_i.lock, 1);
    run(OP_WRITE, 13'h0400, 7'd2, 2);
    check(eeprom_model_i.mem[13'h0400], 8'h30);
    check(eeprom_model_i.mem[13'h0401], 8'h31);
    $display("test arm done");
  endtask
  task automatic t_reset();
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    check(status.locked, 0);
    run(OP_WRITE, 13'h0500, 7'd1, 1);
    check(eeprom_model_i.mem[13'h0500], 8'hFF);
    check(status.timed_out, 1);
    run(OP_DISARM, 13'h0000, 7'd0, 0);
    check(status.locked, 0);
    check(eeprom_model_i.lock, 0);
    $display("test reset done");
  endtask
  // Main sequence
  initial
  begin
    {cmd_valid, byte_valid, byte_data} = '0;
    cmd = '0;
    reset_n = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    t_page();
    t_short();
    t_arm();
    t_reset();
    give_verdict();
  end
  // Watchdog well past the expected run
  initial
  begin
    #200us;
    err_count++;
    give_verdict();
  end
endmodule
